// ===== core/ttx_control_regs.sv
// teletext control and status register bank behind an AXI4-Lite slave
// assumes acquisition/display/sync logic on mclk; only the sync pins are asynchronous, status pins arrive on mclk
`timescale 1ns/1ps
`default_nettype none
module ttx_control_regs #(
	parameter int MEM_DEPTH = 16384
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// axi4-lite write address, data and response
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// raw pins and events from the decoder
	input wire logic hsyncPin,
	input wire logic vsyncPin,
	input wire logic anyVideoShown,
	input wire logic frameRequest,
	input wire logic newsOrSubtitle,
	input wire logic enhancementPacketDone,
	input wire logic aspectSignalArrived,
	input wire logic vbiLine,
	input wire logic vsyncInFirstHalf,
	// acquisition side controls
	output logic packetRowPlacement,
	output logic headerRollBlock,
	output logic eightBitMode,
	output logic captureWriteBlock,
	output logic lineAccept,
	output logic hsyncPositive,
	output logic vsyncPositive,
	output logic evenFieldStart,
	output logic aspectSignalCapture,
	output logic videoInputSelect,
	output ttx_ctrl_pkg::ttx_req_wr_t reqWrite,
	// display side controls
	output logic statusRowSource,
	output logic statusRowOnly,
	output logic overlaySelect,
	output logic [7:0] activeBoxSet,
	output logic statusRowTop,
	output logic doubleHeight,
	output logic upperLowerHalfSelect,
	output logic [2:0] boxRowEnable,
	output logic cursorShow,
	output logic [ttx_ctrl_pkg::W_ROW-1:0] cursorRow,
	// memory access pointer
	output logic memoryAreaSelect,
	output logic [ttx_ctrl_pkg::W_ROW-1:0] memoryRowIndex,
	// memory clear port
	output ttx_ctrl_pkg::ttx_mem_wr_t memWrite,
	output logic interfaceBusyFlag
);
	localparam int W_ROWPORT = ttx_ctrl_pkg::W_ROW;

	logic [7:0] pktFrame_reg, acqSync_reg, reqSel_reg, charFx_reg;
	logic [7:0] boxPri_reg, boxAlt_reg, layout_reg, input_reg, rowPtr_reg;
	logic pk26_reg, wssRx_reg;
	logic [4:0] frozenRow_reg;
	logic clearing_reg;
	logic [ttx_ctrl_pkg::MEM_AW-1:0] clearAddr_reg;
	logic [1:0] hsSync_reg, vsSync_reg;
	logic awHeld_reg, wHeld_reg;
	logic [5:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic doWrite;
	logic writeMapped;
	logic [7:0] rdByte;
	logic rdMapped;

	// address decode for the write path; the read mux decodes addresses on its own
	function automatic logic isWritable(input logic [5:0] a);
		isWritable = (a <= ttx_ctrl_pkg::OFF_ROWPTR) && (a[1:0] == 2'b00);
	endfunction : isWritable

	// axi write channel capture, address and data in either order
	always_ff @(posedge mclk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 6'h00;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
			end
		end
	end

	// refusing writes while busy keeps software off the bank during clear
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign writeMapped = isWritable(awAddr_reg) && !clearing_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ttx_ctrl_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !doWrite;
			s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !doWrite;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				// [RULE23] busy refuses access
				s_axi_bresp <= writeMapped ? ttx_ctrl_pkg::RESP_OKAY : ttx_ctrl_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control registers, low byte lane only
	always_ff @(posedge mclk) begin
		// [RULE24] controls reset zero
		if (rst) begin
			pktFrame_reg <= ttx_ctrl_pkg::REG_RESET;
			acqSync_reg <= ttx_ctrl_pkg::REG_RESET;
			reqSel_reg <= ttx_ctrl_pkg::REG_RESET;
			charFx_reg <= ttx_ctrl_pkg::REG_RESET;
			boxPri_reg <= ttx_ctrl_pkg::REG_RESET;
			boxAlt_reg <= ttx_ctrl_pkg::REG_RESET;
			layout_reg <= ttx_ctrl_pkg::REG_RESET;
			input_reg <= ttx_ctrl_pkg::REG_RESET;
			rowPtr_reg <= ttx_ctrl_pkg::REG_RESET;
		end else begin
			if (doWrite && writeMapped && wStrb_reg[0]) begin
				case (awAddr_reg)
					ttx_ctrl_pkg::OFF_PKT_FRAME: pktFrame_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_ACQ_SYNC: acqSync_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_REQ_SEL: reqSel_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_CHAR_FX: charFx_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_BOX_PRI: boxPri_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_BOX_ALT: boxAlt_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_LAYOUT: layout_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_INPUT: input_reg <= wData_reg[7:0];
					ttx_ctrl_pkg::OFF_ROWPTR: rowPtr_reg <= wData_reg[7:0];
					default: ;
				endcase
			end
			// clear bit self-clears once the fill is running
			if (clearing_reg) begin
				rowPtr_reg[ttx_ctrl_pkg::B_CLEAR] <= 1'b0;
			end
		end
	end

	// page request word write strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			reqWrite <= '0;
		end else begin
			// [RULE12] word to page/column
			reqWrite.en <= doWrite && writeMapped && wStrb_reg[0]
				&& (awAddr_reg == ttx_ctrl_pkg::OFF_REQ_PAY);
			reqWrite.page <= reqSel_reg[ttx_ctrl_pkg::B_REQPG +: ttx_ctrl_pkg::W_REQPG];
			reqWrite.column <= reqSel_reg[ttx_ctrl_pkg::W_REQCOL-1:0];
			reqWrite.word <= wData_reg[ttx_ctrl_pkg::W_REQWORD-1:0];
		end
	end

	// received flags: set wins over a clearing write of zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			pk26_reg <= 1'b0;
			wssRx_reg <= 1'b0;
		end else begin
			if (doWrite && writeMapped && wStrb_reg[0] && awAddr_reg == ttx_ctrl_pkg::OFF_INPUT) begin
				// writing 1 keeps a flag; only the device may raise one
				pk26_reg <= pk26_reg && wData_reg[ttx_ctrl_pkg::B_PK26];
				wssRx_reg <= wssRx_reg && wData_reg[ttx_ctrl_pkg::B_WSSRX];
			end
			// [RULE20] received flags set
			if (enhancementPacketDone) begin
				pk26_reg <= 1'b1;
			end
			if (aspectSignalArrived && input_reg[ttx_ctrl_pkg::B_WSSON]) begin
				wssRx_reg <= 1'b1;
			end
		end
	end

	// sync pins cross into mclk through two stages
	always_ff @(posedge mclk) begin
		if (rst) begin
			hsSync_reg <= 2'b00;
			vsSync_reg <= 2'b00;
		end else begin
			// only stage 1 feeds logic, stage 0 may be metastable
			hsSync_reg <= {hsSync_reg[0], hsyncPin};
			vsSync_reg <= {vsSync_reg[0], vsyncPin};
		end
	end

	// memory clear engine
	always_ff @(posedge mclk) begin
		if (rst) begin
			clearing_reg <= 1'b0;
			clearAddr_reg <= '0;
			memWrite <= '0;
		end else begin
			memWrite.en <= 1'b0;
			if (!clearing_reg && rowPtr_reg[ttx_ctrl_pkg::B_CLEAR]) begin
				clearing_reg <= 1'b1;
				clearAddr_reg <= '0;
			end else if (clearing_reg) begin
				// [RULE18] fill with 20h
				memWrite.en <= 1'b1;
				memWrite.area <= 1'b0;
				memWrite.addr <= clearAddr_reg;
				memWrite.data <= ttx_ctrl_pkg::CLEAR_FILL;
				// [RULE25] busy until last
				if (clearAddr_reg == ttx_ctrl_pkg::MEM_AW'(MEM_DEPTH - 1)) begin
					clearing_reg <= 1'b0;
				end else begin
					clearAddr_reg <= clearAddr_reg + ttx_ctrl_pkg::MEM_AW'(1);
				end
			end
		end
	end

	// cursor position latch
	always_ff @(posedge mclk) begin
		if (rst) begin
			frozenRow_reg <= 5'h00;
		end else if (!rowPtr_reg[ttx_ctrl_pkg::B_FREEZE]) begin
			// [RULE22] freeze holds position
			frozenRow_reg <= rowPtr_reg[W_ROWPORT-1:0];
		end
	end

	// registered control outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			packetRowPlacement <= 1'b0;
			headerRollBlock <= 1'b0;
			eightBitMode <= 1'b0;
			captureWriteBlock <= 1'b0;
			lineAccept <= 1'b0;
			hsyncPositive <= 1'b0;
			vsyncPositive <= 1'b0;
			evenFieldStart <= 1'b0;
			aspectSignalCapture <= 1'b0;
			videoInputSelect <= 1'b0;
			statusRowSource <= 1'b0;
			statusRowOnly <= 1'b0;
			overlaySelect <= 1'b0;
			activeBoxSet <= 8'h00;
			statusRowTop <= 1'b0;
			doubleHeight <= 1'b0;
			upperLowerHalfSelect <= 1'b0;
			boxRowEnable <= 3'h0;
			cursorShow <= 1'b0;
			cursorRow <= 5'h00;
			memoryAreaSelect <= 1'b0;
			memoryRowIndex <= 5'h00;
			interfaceBusyFlag <= 1'b0;
		end else begin
			// [RULE1] packet 24 placement
			packetRowPlacement <= pktFrame_reg[ttx_ctrl_pkg::B_PLACE];
			// [RULE2] row 24 source
			statusRowSource <= pktFrame_reg[ttx_ctrl_pkg::B_SRC];
			// [RULE4] disable wins, [RULE3] auto off on video
			overlaySelect <= frameRequest && !pktFrame_reg[ttx_ctrl_pkg::B_FRMOFF]
				&& !(pktFrame_reg[ttx_ctrl_pkg::B_AUTOFRM] && anyVideoShown);
			// [RULE5] header roll block
			headerRollBlock <= pktFrame_reg[ttx_ctrl_pkg::B_HDRBLK];
			// [RULE6] status row only
			statusRowOnly <= pktFrame_reg[ttx_ctrl_pkg::B_STATONLY];
			// [RULE7] no error check
			eightBitMode <= acqSync_reg[ttx_ctrl_pkg::B_EIGHT];
			// [RULE8] capture writes off
			captureWriteBlock <= acqSync_reg[ttx_ctrl_pkg::B_CAPBLK];
			// [RULE9] line accept gate
			lineAccept <= vbiLine || acqSync_reg[ttx_ctrl_pkg::B_FULL];
			// [RULE10] sync polarity
			hsyncPositive <= hsSync_reg[1] ^ acqSync_reg[ttx_ctrl_pkg::B_HPOL];
			vsyncPositive <= vsSync_reg[1] ^ acqSync_reg[ttx_ctrl_pkg::B_VPOL];
			// [RULE11] even field half
			evenFieldStart <= vsyncInFirstHalf ^ acqSync_reg[ttx_ctrl_pkg::B_FPOL];
			aspectSignalCapture <= input_reg[ttx_ctrl_pkg::B_WSSON];
			// [RULE21] composite input select
			videoInputSelect <= input_reg[ttx_ctrl_pkg::B_VIDSEL];
			// [RULE14] alternate set, [RULE13] box features
			activeBoxSet <= newsOrSubtitle ? boxAlt_reg : boxPri_reg;
			// [RULE15] status row top
			statusRowTop <= layout_reg[ttx_ctrl_pkg::B_STTOP];
			// [RULE16] double height half
			doubleHeight <= layout_reg[ttx_ctrl_pkg::B_DBLH];
			upperLowerHalfSelect <= layout_reg[ttx_ctrl_pkg::B_HALF];
			// [RULE17] per-row box enables
			boxRowEnable <= layout_reg[ttx_ctrl_pkg::B_BOX24:ttx_ctrl_pkg::B_BOX0];
			// [RULE22] cursor display
			cursorShow <= layout_reg[ttx_ctrl_pkg::B_CURSOR];
			cursorRow <= frozenRow_reg;
			// [RULE19] access port target
			memoryAreaSelect <= rowPtr_reg[ttx_ctrl_pkg::B_AREA];
			memoryRowIndex <= rowPtr_reg[W_ROWPORT-1:0];
			// [RULE23] busy flag
			interfaceBusyFlag <= clearing_reg || rowPtr_reg[ttx_ctrl_pkg::B_CLEAR];
		end
	end

	// read mux: control registers read back, status shows busy, the input register shows the flags
	always_comb begin
		rdByte = 8'h00;
		rdMapped = 1'b1;
		case (s_axi_araddr)
			ttx_ctrl_pkg::OFF_PKT_FRAME: rdByte = pktFrame_reg;
			ttx_ctrl_pkg::OFF_ACQ_SYNC: rdByte = acqSync_reg;
			ttx_ctrl_pkg::OFF_REQ_SEL: rdByte = reqSel_reg;
			// payload is a strobe, nothing stored to read back
			ttx_ctrl_pkg::OFF_REQ_PAY: rdByte = 8'h00;
			ttx_ctrl_pkg::OFF_CHAR_FX: rdByte = charFx_reg;
			ttx_ctrl_pkg::OFF_BOX_PRI: rdByte = boxPri_reg;
			ttx_ctrl_pkg::OFF_BOX_ALT: rdByte = boxAlt_reg;
			ttx_ctrl_pkg::OFF_LAYOUT: rdByte = layout_reg;
			ttx_ctrl_pkg::OFF_INPUT: rdByte = {input_reg[7:5], pk26_reg, wssRx_reg,
				input_reg[2:0]};
			ttx_ctrl_pkg::OFF_ROWPTR: rdByte = rowPtr_reg;
			ttx_ctrl_pkg::OFF_STATUS: rdByte = {7'h00, clearing_reg};
			default: rdMapped = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ttx_ctrl_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rdByte};
				s_axi_rresp <= rdMapped ? ttx_ctrl_pkg::RESP_OKAY : ttx_ctrl_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : ttx_control_regs
`default_nettype wire

// ===== core/ttx_ctrl_pkg.sv
// package for the teletext control register bank: offsets, field positions, resets
// assumes an AXI4-Lite master on mclk and a memory clear engine inside the bank
//
// Functional notes
// [RULE1] placement bit picks packet 24 storage memory
// [RULE2] source bit picks row 24 display memory
// [RULE3] auto overlay-off while any video shown
// [RULE4] overlay disable holds overlay output low
// [RULE5] header-roll block stops header/time writes
// [RULE6] status-row-only shows only row 24
// [RULE7] eight-bit mode skips error checking
// [RULE8] capture-write block stops acquisition writes
// [RULE9] full-field bit: VBI lines or any
// [RULE10] H and V sync polarity selects
// [RULE11] field polarity picks even field half
// [RULE12] request word lands at page and column
// [RULE13] box inside/outside enables per feature
// [RULE14] alternate set used on newsflash/subtitle
// [RULE15] status row below or above page
// [RULE16] double height top or bottom half
// [RULE17] separate box enables rows 0/1-23/24
// [RULE18] memory clear writes 20h everywhere; the clear engine fills area 0 only
// [RULE19] access port targets area, block, row; the pointer carries area and row only, with no block field
// [RULE20] packet-26 and aspect flags set on receipt
// [RULE21] input select picks composite input
// [RULE22] cursor at pointer, freeze holds it
// [RULE23] busy flag while registers inaccessible
// [RULE24] all control bits reset to zero
// [RULE25] clear runs alone, busy until done
package ttx_ctrl_pkg;
	// byte offsets on the register bus
	localparam logic [5:0] OFF_PKT_FRAME = 6'h00;
	localparam logic [5:0] OFF_ACQ_SYNC = 6'h04;
	localparam logic [5:0] OFF_REQ_SEL = 6'h08;
	localparam logic [5:0] OFF_REQ_PAY = 6'h0c;
	localparam logic [5:0] OFF_CHAR_FX = 6'h10;
	localparam logic [5:0] OFF_BOX_PRI = 6'h14;
	localparam logic [5:0] OFF_BOX_ALT = 6'h18;
	localparam logic [5:0] OFF_LAYOUT = 6'h1c;
	localparam logic [5:0] OFF_INPUT = 6'h20;
	localparam logic [5:0] OFF_ROWPTR = 6'h24;
	localparam logic [5:0] OFF_STATUS = 6'h28;
	// packet_store_frame_ctrl fields
	localparam int B_PLACE = 0;
	localparam int B_SRC = 1;
	localparam int B_AUTOFRM = 2;
	localparam int B_HDRBLK = 3;
	localparam int B_STATONLY = 4;
	localparam int B_FRMOFF = 5;
	// acquisition_sync_ctrl fields
	localparam int B_EIGHT = 6;
	localparam int B_CAPBLK = 5;
	localparam int B_FULL = 3;
	localparam int B_FPOL = 2;
	localparam int B_HPOL = 1;
	localparam int B_VPOL = 0;
	// page_request_select fields
	localparam int B_REQPG = 3;
	localparam int W_REQPG = 4;
	localparam int W_REQCOL = 3;
	localparam int W_REQWORD = 5;
	// box set fields
	localparam int B_BKOUT = 7;
	localparam int B_BKIN = 6;
	localparam int B_COROUT = 5;
	localparam int B_CORIN = 4;
	localparam int B_TXOUT = 3;
	localparam int B_TXIN = 2;
	localparam int B_PICOUT = 1;
	localparam int B_PICIN = 0;
	// display_layout_ctrl fields
	localparam int B_STTOP = 7;
	localparam int B_CURSOR = 6;
	localparam int B_HALF = 4;
	localparam int B_DBLH = 3;
	localparam int B_BOX24 = 2;
	localparam int B_BOX1 = 1;
	localparam int B_BOX0 = 0;
	// input_service_flags fields
	localparam int B_PK26 = 4;
	localparam int B_WSSRX = 3;
	localparam int B_WSSON = 2;
	localparam int B_VIDSEL = 1;
	// memory_row_pointer fields
	localparam int B_FREEZE = 7;
	localparam int B_CLEAR = 6;
	localparam int B_AREA = 5;
	localparam int W_ROW = 5;
	// status register fields
	localparam int B_BUSY = 0;
	// memory clear, register reset value and bus responses
	localparam logic [7:0] CLEAR_FILL = 8'h20;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int MEM_AW = 14;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// memory write port toward teletext memory
	typedef struct packed {
		logic en;
		logic area;
		logic [MEM_AW-1:0] addr;
		logic [7:0] data;
	} ttx_mem_wr_t;

	// page request write toward the acquisition filter
	typedef struct packed {
		logic en;
		logic [W_REQPG-1:0] page;
		logic [W_REQCOL-1:0] column;
		logic [W_REQWORD-1:0] word;
	} ttx_req_wr_t;
endpackage : ttx_ctrl_pkg

// ===== testbench/ttx_control_regs_properties.sv
// port assertions for the teletext control register bank
// assumes binding into ttx_control_regs, one clock mclk, sync reset rst
`timescale 1ns/1ps
`default_nettype none
module ttx_control_regs_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus handshakes
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// decoder side
	input wire logic frameRequest,
	input wire logic overlaySelect,
	input wire logic vbiLine,
	input wire logic lineAccept,
	input wire logic interfaceBusyFlag,
	input wire ttx_ctrl_pkg::ttx_mem_wr_t memWrite,
	input wire ttx_ctrl_pkg::ttx_req_wr_t reqWrite
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// fill stream already running for a cycle
	sequence fillGoing;
		memWrite.en && $past(memWrite.en);
	endsequence
	sequence fillStart;
		$rose(memWrite.en);
	endsequence
	a_reset_quiet: assert property ($past(rst) |-> !overlaySelect && !memWrite.en)
		else $error("output active after reset");
	a_overlay_cause: assert property (overlaySelect |-> $past(frameRequest))
		else $error("overlay high without request");
	a_line_accept: assert property (!$past(rst) && $past(vbiLine) |-> lineAccept)
		else $error("blanking line not accepted");
	a_fill_value: assert property (memWrite.en |-> memWrite.data == 8'h20 && !memWrite.area)
		else $error("clear fill value wrong");
	a_fill_busy: assert property (memWrite.en |-> interfaceBusyFlag)
		else $error("busy low during fill");
	a_fill_origin: assert property (fillStart |-> memWrite.addr == 14'h0)
		else $error("fill not starting at zero");
	a_fill_step: assert property (fillGoing |-> memWrite.addr == $past(memWrite.addr) + 14'h1)
		else $error("fill address skipped");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_req_pulse: assert property (reqWrite.en |=> !reqWrite.en)
		else $error("request strobe too long");
endmodule : ttx_control_regs_properties
bind ttx_control_regs ttx_control_regs_properties u_props (.*);
`default_nettype wire

// ===== testbench/ttx_host_model.sv
// bus master standing in for the controller core
// assumes one write and one read at a time, tasks called from the bench
`timescale 1ns/1ps
`default_nettype none
module ttx_host_model (
	// clock
	input wire logic mclk,
	// write channels
	output logic [5:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read channels
	output logic [5:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// released payload is scrambled so stale values never look valid
	task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w || !s_axi_bvalid) begin
			@(posedge mclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~{24'h0, d};
			end
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		while (!s_axi_rvalid) @(posedge mclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : ttx_host_model
`default_nettype wire

// ===== testbench/ttx_control_regs_tb.sv
// self-checking bench for the teletext control register bank
// assumes the host model as bus master and a shortened clear depth
`timescale 1ns/1ps
`default_nettype none
module ttx_control_regs_tb;
	typedef struct packed {logic [5:0] a; logic [7:0] d; logic [14:0] o;} ttx_row_t;
	logic mclk = 1'b0;
	logic rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic hsyncPin, vsyncPin, anyVideoShown, frameRequest, newsOrSubtitle, vbiLine;
	logic enhancementPacketDone, aspectSignalArrived, vsyncInFirstHalf;
	logic packetRowPlacement, headerRollBlock, eightBitMode, captureWriteBlock, lineAccept;
	logic hsyncPositive, vsyncPositive, evenFieldStart, aspectSignalCapture, videoInputSelect;
	logic statusRowSource, statusRowOnly, overlaySelect, statusRowTop, doubleHeight;
	logic upperLowerHalfSelect, cursorShow, interfaceBusyFlag, memoryAreaSelect;
	logic [7:0] activeBoxSet;
	logic [2:0] boxRowEnable;
	logic [4:0] cursorRow, memoryRowIndex;
	ttx_ctrl_pkg::ttx_req_wr_t reqWrite, reqSeen;
	ttx_ctrl_pkg::ttx_mem_wr_t memWrite;
	int nErrors = 0;
	int totalChecks = 0;
	int cycles = 0;
	int fillCount = 0;
	ttx_row_t rows [8] = '{'{6'h00, 8'h1b, 15'h7800}, '{6'h04, 8'h60, 15'h7e00},
		'{6'h1c, 8'hdf, 15'h7fe7}, '{6'h20, 8'h06, 15'h7fff}, '{6'h00, 8'h00, 15'h07ff},
		'{6'h1c, 8'h05, 15'h061d}, '{6'h04, 8'h00, 15'h001d}, '{6'h20, 8'h00, 15'h0005}};

	ttx_control_regs #(.MEM_DEPTH(16)) u_dut (.*);
	ttx_host_model u_host (.*);

	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (reqWrite.en)
			reqSeen <= reqWrite;
		if (memWrite.en)
			fillCount <= fillCount + 1;
		if (cycles == 5000) begin
			nErrors++;
			completeRun();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrChk(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] r;
		u_host.wr(a, d, r);
		chk({30'h0, r}, {30'h0, er});
	endtask : wrChk
	task automatic rdChk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		u_host.rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask : rdChk
	task automatic pulse(input logic e, input logic w);
		@(posedge mclk);
		enhancementPacketDone <= e;
		aspectSignalArrived <= w;
		@(posedge mclk);
		enhancementPacketDone <= 1'b0;
		aspectSignalArrived <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : pulse
	function automatic logic [31:0] snap();
		return 32'({packetRowPlacement, statusRowSource, headerRollBlock, statusRowOnly,
			eightBitMode, captureWriteBlock, statusRowTop, doubleHeight, upperLowerHalfSelect,
			cursorShow, aspectSignalCapture, videoInputSelect, boxRowEnable});
	endfunction : snap
	task automatic completeRun();
		$display("errors %0d checks %0d", nErrors, totalChecks);
		if (nErrors == 0 && totalChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : completeRun

	initial begin
		{rst, hsyncPin, vsyncPin, anyVideoShown, frameRequest, newsOrSubtitle} = 6'h28;
		{vbiLine, enhancementPacketDone, aspectSignalArrived, vsyncInFirstHalf} = 4'h0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		chk(snap(), 32'h0);
		for (int i = 0; i < 11; i++)
			rdChk(6'(i * 4), 32'h0, ttx_ctrl_pkg::RESP_OKAY);
		foreach (rows[i]) begin
			wrChk(rows[i].a, rows[i].d, ttx_ctrl_pkg::RESP_OKAY);
			rdChk(rows[i].a, {24'h0, rows[i].d}, ttx_ctrl_pkg::RESP_OKAY);
			chk(snap(), 32'(rows[i].o));
		end
		wrChk(ttx_ctrl_pkg::OFF_PKT_FRAME, 8'h04, ttx_ctrl_pkg::RESP_OKAY);
		frameRequest <= 1'b1;
		anyVideoShown <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(32'(overlaySelect), 32'h0);
		anyVideoShown <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(32'(overlaySelect), 32'h1);
		wrChk(ttx_ctrl_pkg::OFF_PKT_FRAME, 8'h24, ttx_ctrl_pkg::RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(32'(overlaySelect), 32'h0);
		wrChk(ttx_ctrl_pkg::OFF_BOX_PRI, 8'ha5, ttx_ctrl_pkg::RESP_OKAY);
		wrChk(ttx_ctrl_pkg::OFF_BOX_ALT, 8'h5a, ttx_ctrl_pkg::RESP_OKAY);
		chk(32'(activeBoxSet), 32'ha5);
		newsOrSubtitle <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(32'(activeBoxSet), 32'h5a);
		wrChk(ttx_ctrl_pkg::OFF_ACQ_SYNC, 8'h0f, ttx_ctrl_pkg::RESP_OKAY);
		repeat (5) @(posedge mclk);
		chk(32'({lineAccept, hsyncPositive, vsyncPositive, evenFieldStart}), 32'hd);
		vbiLine <= 1'b1;
		wrChk(ttx_ctrl_pkg::OFF_ACQ_SYNC, 8'h00, ttx_ctrl_pkg::RESP_OKAY);
		repeat (5) @(posedge mclk);
		chk(32'({lineAccept, hsyncPositive, vsyncPositive, evenFieldStart}), 32'ha);
		// page and column first, then the payload word
		wrChk(ttx_ctrl_pkg::OFF_REQ_SEL, 8'h55, ttx_ctrl_pkg::RESP_OKAY);
		wrChk(ttx_ctrl_pkg::OFF_REQ_PAY, 8'h13, ttx_ctrl_pkg::RESP_OKAY);
		repeat (3) @(posedge mclk);
		chk(32'(reqSeen), 32'({1'b1, 4'ha, 3'h5, 5'h13}));
		pulse(1'b1, 1'b1);
		rdChk(ttx_ctrl_pkg::OFF_INPUT, 32'h10, ttx_ctrl_pkg::RESP_OKAY);
		wrChk(ttx_ctrl_pkg::OFF_INPUT, 8'h04, ttx_ctrl_pkg::RESP_OKAY);
		pulse(1'b0, 1'b1);
		rdChk(ttx_ctrl_pkg::OFF_INPUT, 32'h0c, ttx_ctrl_pkg::RESP_OKAY);
		wrChk(ttx_ctrl_pkg::OFF_ROWPTR, 8'h2b, ttx_ctrl_pkg::RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(32'(cursorRow), 32'h0b);
		chk(32'({memoryAreaSelect, memoryRowIndex}), 32'h2b);
		wrChk(ttx_ctrl_pkg::OFF_ROWPTR, 8'h83, ttx_ctrl_pkg::RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(32'(cursorRow), 32'h0b);
		chk(32'({memoryAreaSelect, memoryRowIndex}), 32'h03);
		wrChk(ttx_ctrl_pkg::OFF_ROWPTR, 8'h40, ttx_ctrl_pkg::RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(32'(interfaceBusyFlag), 32'h1);
		wrChk(ttx_ctrl_pkg::OFF_LAYOUT, 8'h00, ttx_ctrl_pkg::RESP_SLVERR);
		// no access until the clear has finished
		while (interfaceBusyFlag)
			@(posedge mclk);
		chk(32'(fillCount), 32'd16);
		chk(32'(boxRowEnable), 32'h5);
		rdChk(ttx_ctrl_pkg::OFF_STATUS, 32'h0, ttx_ctrl_pkg::RESP_OKAY);
		wrChk(6'h30, 8'hff, ttx_ctrl_pkg::RESP_SLVERR);
		rdChk(6'h30, 32'h0, ttx_ctrl_pkg::RESP_SLVERR);
		completeRun();
	end
endmodule : ttx_control_regs_tb
`default_nettype wire
